// *** bench/giaoc_pin_model.sv ***
`default_nettype none
module giaoc_pin_model (
  // Clock.
  input wire logic clk_sys,
  // Event requests from the bench and the pin events they become.
  input wire logic [31:0] ev_req,
  output logic [31:0] pin_event,
  // Watched output pins and their last measured phase lengths.
  input wire logic [1:0] pin_out,
  output logic [15:0] hi_a,
  output logic [15:0] lo_a,
  output logic [15:0] hi_b,
  output logic [15:0] lo_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prev;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;

  initial begin
    pin_event = 32'h0000_0000;
    prev = 2'h0;
    cnt_a = 16'h0000;
    cnt_b = 16'h0000;
    {hi_a, lo_a, hi_b, lo_b} = 64'h0;
  end

  always @(posedge clk_sys) begin
    pin_event <= ev_req;
  end

  always @(posedge clk_sys) begin
    prev <= pin_out;
    if (pin_out[0] != prev[0]) begin
      if (prev[0]) hi_a <= cnt_a;
      else lo_a <= cnt_a;
      cnt_a <= 16'h0001;
    end else cnt_a <= cnt_a + 16'h0001;
    if (pin_out[1] != prev[1]) begin
      if (prev[1]) hi_b <= cnt_b;
      else lo_b <= cnt_b;
      cnt_b <= 16'h0001;
    end else cnt_b <= cnt_b + 16'h0001;
  end
endmodule : giaoc_pin_model
`default_nettype wire

// *** bench/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import giaoc_pkg::*;
  localparam int TBC = 4;
  logic clk_sys, rst_n, io_wr, io_rd, sci_r, smi_r;
  logic interrupt_type_select, gpio_interrupt_gate, gpio_mgmt_interrupt_force;
  logic [7:0] io_addr;
  logic [3:0] io_be, ioapic_irq_r;
  logic [31:0] io_wdata, io_rdata_r, gpio_in, pin_event, ev_req;
  logic [31:0] gpio_out_data, gpio_out_en, outclk_route_en, outclk_route_b;
  logic [31:0] gpio_out_r, gpio_oe_r;
  logic [15:0] hi_a, lo_a, hi_b, lo_b;
  int n_errors = 0;
  int checked = 0;

  giaoc_top #(.TB_BASE_CYC_P(TBC)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be),
    .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
    .interrupt_type_select(interrupt_type_select),
    .gpio_interrupt_gate(gpio_interrupt_gate),
    .gpio_mgmt_interrupt_force(gpio_mgmt_interrupt_force),
    .sci_r(sci_r), .smi_r(smi_r), .gpio_in(gpio_in), .pin_event(pin_event),
    .ioapic_irq_r(ioapic_irq_r), .gpio_out_data(gpio_out_data),
    .gpio_out_en(gpio_out_en), .outclk_route_en(outclk_route_en),
    .outclk_route_b(outclk_route_b), .gpio_out_r(gpio_out_r),
    .gpio_oe_r(gpio_oe_r));

  giaoc_pin_model pins_u (.clk_sys(clk_sys), .ev_req(ev_req),
    .pin_event(pin_event), .pin_out(gpio_out_r[1:0]), .hi_a(hi_a),
    .lo_a(lo_a), .hi_b(hi_b), .lo_b(lo_b));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] v);
    @(posedge clk_sys);
    io_wr <= 1'b1;
    io_addr <= a;
    io_be <= be;
    io_wdata <= v;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1 chk(io_rdata_r, exp);
  endtask : rchk

  task automatic t_reset();
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    rchk(OFS_IRQ_ENABLE, 32'h0000_0000);
    rchk(OFS_OUTCLK_CFG, 32'hffff_ffff);
    rchk(8'he0, 32'h0000_0000);
  endtask : t_reset

  task automatic t_status();
    @(posedge clk_sys);
    ev_req <= 32'h8000_0001;
    @(posedge clk_sys);
    ev_req <= 32'h0000_0000;
    repeat (2) @(posedge clk_sys);
    rchk(OFS_IRQ_STATUS, 32'h8000_0001);
    wr(OFS_IRQ_STATUS, 4'hf, 32'h0000_0001);
    rchk(OFS_IRQ_STATUS, 32'h8000_0000);
    wr(OFS_IRQ_STATUS, 4'hf, 32'h0000_0000);
    rchk(OFS_IRQ_STATUS, 32'h8000_0000);
    wr(OFS_IRQ_STATUS, 4'h7, 32'hffff_ffff);
    rchk(OFS_IRQ_STATUS, 32'h8000_0000);
  endtask : t_status

  task automatic t_irq();
    logic [2:0] c;
    wr(OFS_IRQ_ENABLE, 4'hf, 32'h8000_0000);
    rchk(OFS_IRQ_ENABLE, 32'h8000_0000);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      @(posedge clk_sys);
      {gpio_interrupt_gate, gpio_mgmt_interrupt_force} <= c[2:1];
      interrupt_type_select <= c[0];
      repeat (2) @(posedge clk_sys);
      #1 chk({sci_r, smi_r}, {c[2] & c[0], c[1] | (c[2] & ~c[0])});
    end
    wr(OFS_IRQ_ENABLE, 4'hf, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    #1 chk({sci_r, smi_r}, 2'h0);
    wr(OFS_IRQ_ENABLE, 4'hf, 32'h8000_0000);
    wr(OFS_IRQ_STATUS, 4'h8, 32'hffff_ffff);
    rchk(OFS_IRQ_STATUS, 32'h0000_0000);
    #1 chk({sci_r, smi_r}, 2'h0);
  endtask : t_irq

  task automatic t_ioapic();
    @(posedge clk_sys);
    gpio_in <= 32'h0002_0004;
    repeat (2) @(posedge clk_sys);
    #1 chk(ioapic_irq_r, 4'h9);
    @(posedge clk_sys);
    gpio_in <= 32'hfffd_fffb;
    repeat (2) @(posedge clk_sys);
    #1 chk(ioapic_irq_r, 4'h6);
  endtask : t_ioapic

  task automatic t_clk();
    @(posedge clk_sys);
    outclk_route_en <= 32'h0000_0003;
    outclk_route_b <= 32'h0000_0002;
    gpio_out_en <= 32'h0000_0004;
    gpio_out_data <= 32'h0000_0004;
    wr(OFS_OUTCLK_CFG, 4'hf, 32'h4181_0282);
    rchk(OFS_OUTCLK_CFG, 32'h4181_0282);
    repeat (5000) @(posedge clk_sys);
    #1 chk(gpio_oe_r, 32'h0000_0007);
    chk(gpio_out_r[2], 1'b1);
    chk(hi_a, 6 * TBC);
    chk(lo_a, 3 * TBC);
    chk(hi_b, 4 * TB_STEP_RATIO * TBC);
    chk(lo_b, 2 * TB_STEP_RATIO * TBC);
    wr(OFS_OUTCLK_CFG, 4'hf, 32'hc000_8000);
    // A phase in flight keeps its old count at the new rate and may take four slow ticks,
    // so two whole new phases need about six 128 ms ticks.
    repeat (12500) @(posedge clk_sys);
    #1 chk(hi_a, 64 * TBC);
    chk(lo_a, 64 * TBC);
    chk(hi_b, 512 * TBC);
    chk(lo_b, 512 * TBC);
  endtask : t_clk

  initial begin
    {rst_n, io_wr, io_rd, interrupt_type_select} = 4'h0;
    {gpio_interrupt_gate, gpio_mgmt_interrupt_force} = 2'h0;
    {io_addr, io_be, io_wdata, ev_req, gpio_in} = 108'h0;
    {gpio_out_data, gpio_out_en, outclk_route_en, outclk_route_b} = 128'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_status();
    t_irq();
    t_ioapic();
    t_clk();
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// *** design/giaoc_outclk.sv ***
`default_nettype none
module giaoc_outclk
  import giaoc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timebase tick and phase times.
  input wire logic tick,
  input wire logic [giaoc_pkg::TIME_W-1:0] high_time,
  input wire logic [giaoc_pkg::TIME_W-1:0] low_time,
  // Generated clock level.
  output logic level_r
);
  import giaoc_pkg::*;

  logic [TIME_W-1:0] cnt_r;
  logic [TIME_W-1:0] cnt_nxt;
  logic level_nxt;

  // RULE_06 down counter reload
  always_comb begin
    cnt_nxt = cnt_r;
    level_nxt = level_r;
    if (tick) begin
      // RULE_15 expire and toggle
      if (cnt_r == '0) begin
        level_nxt = ~level_r;
        cnt_nxt = level_r ? low_time : high_time;
      end else begin
        cnt_nxt = cnt_r - 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r <= RST_OUTCLK_CNT;
      level_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_expire;
    tick && cnt_r == '0;
  endsequence

  a_reload_phase: assert property ( // RULE_06
    s_expire |=> level_r != $past(level_r) &&
      cnt_r == (level_r ? $past(high_time) : $past(low_time)))
    else $error("Output clock did not reload the opposite phase time.");

  a_count_down: assert property ( // RULE_15
    tick && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 7'h01 && $stable(level_r))
    else $error("Output clock counter did not step down by one.");

  a_hold_no_tick: assert property ( // RULE_15
    !tick |=> $stable(cnt_r) && $stable(level_r))
    else $error("Output clock moved without a timebase tick.");
endmodule : giaoc_outclk
`default_nettype wire

// *** design/giaoc_pkg.sv ***
`default_nettype none
package giaoc_pkg;
  // Geometry.
  localparam int unsigned PIN_CNT = 32;
  localparam int unsigned OUTCLK_CNT = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;

  // Register offsets on the I/O port.
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hd4;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'hd8;
  localparam logic [7:0] OFS_OUTCLK_CFG = 8'hdc;

  // Values after reset.
  localparam logic [31:0] RST_IRQ_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_OUTCLK_CFG = 32'hffff_ffff;
  localparam logic [6:0] RST_OUTCLK_CNT = 7'h7f;

  // Output clock configuration fields, clock a; clock b sits one stride up.
  localparam int unsigned TIME_W = 7;
  localparam int unsigned TB_W = 2;
  localparam int unsigned LOW_LSB = 0;
  localparam int unsigned HIGH_LSB = 7;
  localparam int unsigned TB_LSB = 14;
  localparam int unsigned OUTCLK_STRIDE = 16;

  // Pins whose input path also feeds the interrupt controller.
  localparam int unsigned IOAPIC_CNT = 4;
  localparam int unsigned IOAPIC_PIN0 = 2;
  localparam int unsigned IOAPIC_PIN1 = 3;
  localparam int unsigned IOAPIC_PIN2 = 16;
  localparam int unsigned IOAPIC_PIN3 = 17;

  // Timebases.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TB_BASE_US = 250;
  localparam int unsigned TB_2MS_US = 2000;
  localparam int unsigned TB_BASE_CYC = TB_BASE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TB_STEP_RATIO = TB_2MS_US / TB_BASE_US;
  localparam int unsigned TB_STAGES = 3;

  typedef enum logic [1:0] {
    TB_250US,
    TB_2MS,
    TB_16MS,
    TB_128MS
  } giaoc_tb_t;
endpackage : giaoc_pkg
`default_nettype wire

// *** design/giaoc_top.sv ***
// What this block does
// RULE_01: Thirty-two status bits each hold the latched event of one pin.
// RULE_02: Writing one to a status bit clears its latch; zero leaves it.
// RULE_03: An enabled set status bit raises the interrupt type selected.
// RULE_04: With the gate low, the per-pin path raises neither interrupt.
// RULE_05: A high force bit raises a management interrupt despite the gate.
// RULE_06: Each clock is a 7-bit down counter fed high and low time in turn.
// RULE_07: Low phase lasts low time plus one ticks, fields 6:0 and 22:16.
// RULE_08: High phase lasts high time plus one ticks, fields 13:7 and 29:23.
// RULE_09: Timebase codes 00 to 11 pick 250 us, 2 ms, 16 ms or 128 ms ticks.
// RULE_10: Bits 15:14 pick the timebase of clock a, bits 31:30 that of b.
// RULE_11: Either output clock can be driven out on any pin.
// RULE_12: Pins 2, 3, 16 and 17 always feed the interrupt controller.
// RULE_13: The output clock configuration resets to all ones.
// RULE_14: Status and enable registers reset to all zeros.
// RULE_15: Counters step per tick, toggle at zero and load the other phase.
`default_nettype none
module giaoc_top
  import giaoc_pkg::*;
#(
  parameter int unsigned TB_BASE_CYC_P = giaoc_pkg::TB_BASE_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register I/O port.
  input wire logic [giaoc_pkg::ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [giaoc_pkg::BE_W-1:0] io_be,
  input wire logic [giaoc_pkg::DATA_W-1:0] io_wdata,
  output logic [giaoc_pkg::DATA_W-1:0] io_rdata_r,
  // Global interrupt control.
  input wire logic interrupt_type_select,
  input wire logic gpio_interrupt_gate,
  input wire logic gpio_mgmt_interrupt_force,
  output logic sci_r,
  output logic smi_r,
  // Pin input path.
  input wire logic [giaoc_pkg::PIN_CNT-1:0] gpio_in,
  input wire logic [giaoc_pkg::PIN_CNT-1:0] pin_event,
  output logic [giaoc_pkg::IOAPIC_CNT-1:0] ioapic_irq_r,
  // Pin output path.
  input wire logic [giaoc_pkg::PIN_CNT-1:0] gpio_out_data,
  input wire logic [giaoc_pkg::PIN_CNT-1:0] gpio_out_en,
  input wire logic [giaoc_pkg::PIN_CNT-1:0] outclk_route_en,
  input wire logic [giaoc_pkg::PIN_CNT-1:0] outclk_route_b,
  output logic [giaoc_pkg::PIN_CNT-1:0] gpio_out_r,
  output logic [giaoc_pkg::PIN_CNT-1:0] gpio_oe_r
);
  import giaoc_pkg::*;

  localparam int unsigned PRE_W = $clog2(TB_BASE_CYC_P + 1);
  localparam int unsigned DIV_W = $clog2(TB_STEP_RATIO);

  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  // ---- Register file ----
  logic [DATA_W-1:0] status_r;
  logic [DATA_W-1:0] status_nxt;
  logic [DATA_W-1:0] enable_r;
  logic [DATA_W-1:0] enable_nxt;
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] cfg_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] wmask;
  logic wr_status;
  logic wr_enable;
  logic wr_cfg;

  always_comb begin
    wmask = lane_mask(io_be);
    wr_status = io_wr && io_addr == OFS_IRQ_STATUS;
    wr_enable = io_wr && io_addr == OFS_IRQ_ENABLE;
    wr_cfg = io_wr && io_addr == OFS_OUTCLK_CFG;
    status_nxt = status_r;
    // RULE_02 write one clears
    if (wr_status) begin
      status_nxt = status_r & ~(io_wdata & wmask);
    end
    // RULE_01 latch pin events
    // A new event in the clearing cycle survives the clear.
    status_nxt = status_nxt | pin_event;
    enable_nxt = wr_enable ?
      (enable_r & ~wmask) | (io_wdata & wmask) : enable_r;
    cfg_nxt = wr_cfg ? (cfg_r & ~wmask) | (io_wdata & wmask) : cfg_r;
    rdata_nxt = io_rdata_r;
    if (io_rd) begin
      unique case (io_addr)
        OFS_IRQ_STATUS: rdata_nxt = status_r;
        OFS_IRQ_ENABLE: rdata_nxt = enable_r;
        OFS_OUTCLK_CFG: rdata_nxt = cfg_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // RULE_14 clear on reset
      status_r <= RST_IRQ_STATUS;
      enable_r <= RST_IRQ_ENABLE;
      // RULE_13 slowest clocks
      cfg_r <= RST_OUTCLK_CFG;
      io_rdata_r <= '0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      cfg_r <= cfg_nxt;
      io_rdata_r <= rdata_nxt;
    end
  end

  // ---- Interrupt routing ----
  logic pending;
  logic sci_nxt;
  logic smi_nxt;
  logic [IOAPIC_CNT-1:0] ioapic_nxt;

  always_comb begin
    pending = |(status_r & enable_r);
    // RULE_03 select interrupt type
    // RULE_04 gate per-pin path
    sci_nxt = pending && gpio_interrupt_gate && interrupt_type_select;
    // RULE_05 management force
    smi_nxt = pending && (gpio_mgmt_interrupt_force ||
      (gpio_interrupt_gate && !interrupt_type_select));
    // RULE_12 ungated controller feed
    ioapic_nxt = {gpio_in[IOAPIC_PIN3], gpio_in[IOAPIC_PIN2],
      gpio_in[IOAPIC_PIN1], gpio_in[IOAPIC_PIN0]};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sci_r <= 1'b0;
      smi_r <= 1'b0;
      ioapic_irq_r <= '0;
    end else begin
      sci_r <= sci_nxt;
      smi_r <= smi_nxt;
      ioapic_irq_r <= ioapic_nxt;
    end
  end

  // ---- Timebase ----
  // One shared prescaler and a divide-by-eight chain keep every timebase
  // phase-aligned, so both clocks on the same base stay in step.
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [TB_STAGES:0] tb_tick;

  always_comb begin
    tb_tick[0] = pre_r == PRE_W'(TB_BASE_CYC_P - 1);
    pre_nxt = tb_tick[0] ? '0 : pre_r + PRE_W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // RULE_09 timebase periods
  for (genvar k = 0; k < TB_STAGES; k++) begin : g_div
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;

    always_comb begin
      div_nxt = tb_tick[k] ? div_r + DIV_W'(1) : div_r;
      tb_tick[k+1] = tb_tick[k] && div_r == DIV_W'(TB_STEP_RATIO - 1);
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        div_r <= '0;
      end else begin
        div_r <= div_nxt;
      end
    end
  end

  // ---- Output clocks ----
  logic [OUTCLK_CNT-1:0] outclk_level;
  logic [OUTCLK_CNT-1:0] outclk_tick;

  for (genvar c = 0; c < OUTCLK_CNT; c++) begin : g_outclk
    giaoc_tb_t tb_sel;

    // RULE_10 per-clock timebase
    always_comb begin
      tb_sel = giaoc_tb_t'(cfg_r[c*OUTCLK_STRIDE + TB_LSB +: TB_W]);
      unique case (tb_sel)
        TB_250US: outclk_tick[c] = tb_tick[0];
        TB_2MS: outclk_tick[c] = tb_tick[1];
        TB_16MS: outclk_tick[c] = tb_tick[2];
        TB_128MS: outclk_tick[c] = tb_tick[3];
      endcase
    end

    // RULE_07 low time field
    // RULE_08 high time field
    giaoc_outclk u_outclk (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(outclk_tick[c]),
      .high_time(cfg_r[c*OUTCLK_STRIDE + HIGH_LSB +: TIME_W]),
      .low_time(cfg_r[c*OUTCLK_STRIDE + LOW_LSB +: TIME_W]),
      .level_r(outclk_level[c])
    );
  end

  // ---- Pin output mux ----
  logic [PIN_CNT-1:0] out_nxt;
  logic [PIN_CNT-1:0] oe_nxt;

  // RULE_11 clock on any pin
  for (genvar n = 0; n < PIN_CNT; n++) begin : g_pin
    always_comb begin
      out_nxt[n] = outclk_route_en[n] ?
        outclk_level[outclk_route_b[n]] : gpio_out_data[n];
      oe_nxt[n] = outclk_route_en[n] || gpio_out_en[n];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gpio_out_r <= '0;
      gpio_oe_r <= '0;
    end else begin
      gpio_out_r <= out_nxt;
      gpio_oe_r <= oe_nxt;
    end
  end

  // ---- Checks ----
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_status_write;
    io_wr && io_addr == OFS_IRQ_STATUS && io_be == 4'hf;
  endsequence

  a_event_latch: assert property ( // RULE_01
    ##1 (status_r & $past(pin_event)) == $past(pin_event))
    else $error("Pin event was not latched into status.");

  a_w1c_clear: assert property ( // RULE_02
    (s_status_write and pin_event == '0) |=>
      status_r == ($past(status_r) & ~$past(io_wdata)))
    else $error("Status write did not clear exactly the ones written.");

  a_sci_route: assert property ( // RULE_03
    pending && gpio_interrupt_gate && interrupt_type_select |=> sci_r)
    else $error("Enabled status did not raise the control interrupt.");

  a_gate_off: assert property ( // RULE_04
    !gpio_interrupt_gate && !gpio_mgmt_interrupt_force |=> !sci_r && !smi_r)
    else $error("Interrupt raised while the gate was low.");

  a_smi_force: assert property ( // RULE_05
    pending && gpio_mgmt_interrupt_force |=> smi_r)
    else $error("Force bit did not raise the management interrupt.");

  a_ioapic_feed: assert property ( // RULE_12
    ##1 ioapic_irq_r == {$past(gpio_in[IOAPIC_PIN3]),
      $past(gpio_in[IOAPIC_PIN2]), $past(gpio_in[IOAPIC_PIN1]),
      $past(gpio_in[IOAPIC_PIN0])})
    else $error("Controller feed did not follow the designated pins.");

  a_reset_values: assert property ( // RULE_13
    $past(!rst_n) |-> cfg_r == RST_OUTCLK_CFG &&
      status_r == RST_IRQ_STATUS && enable_r == RST_IRQ_ENABLE)
    else $error("Registers did not take their reset values.");

  a_tick_chain: assert property ( // RULE_09
    tb_tick[1] |-> tb_tick[0] && g_div[0].div_r == DIV_W'(TB_STEP_RATIO - 1))
    else $error("Slower timebase ticked off the base tick.");

  // Cycles between 2 ms ticks, counted apart from the divider chain so that
  // the period check does not merely restate the chain's own compare.
  localparam int unsigned MID_CYC = TB_STEP_RATIO * TB_BASE_CYC_P;
  localparam int unsigned GAP_W = $clog2(MID_CYC + 1);
  logic [GAP_W-1:0] mid_gap_r;
  logic [GAP_W-1:0] mid_gap_nxt;

  always_comb begin
    mid_gap_nxt = tb_tick[1] ? '0 : mid_gap_r + GAP_W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mid_gap_r <= '0;
    end else begin
      mid_gap_r <= mid_gap_nxt;
    end
  end

  a_mid_period: assert property ( // RULE_09
    tb_tick[1] |-> mid_gap_r == GAP_W'(MID_CYC - 1))
    else $error("Two millisecond tick came at the wrong period.");

  a_pin_route: assert property ( // RULE_11
    outclk_route_en[0] |=> gpio_oe_r[0] &&
      gpio_out_r[0] == $past(outclk_level[outclk_route_b[0]]))
    else $error("Routed output clock did not reach the pin.");
endmodule : giaoc_top
`default_nettype wire
